// ---- bdcr_defines.vh ----
// register map, field positions, reset values and timing constants
`ifndef BDCR_DEFINES_VH
`define BDCR_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define BDCR_ADDR_CMD        6'h08
`define BDCR_ADDR_DRV_IN     6'h09
`define BDCR_ADDR_CFG_FAULT  6'h0A
`define BDCR_ADDR_CFG_DIAG   6'h0B
`define BDCR_ADDR_CFG_TIME   6'h0C
`define BDCR_ADDR_CFG_COMB   6'h0D

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BDCR_RST_CMD         8'h09
`define BDCR_RST_DRV_IN      8'h0C
`define BDCR_RST_CFG_FAULT   8'h10
`define BDCR_RST_CFG_DIAG    8'h00
`define BDCR_RST_CFG_TIME    8'h40
`define BDCR_RST_CFG_COMB    8'h04

// ----------------------------------------------------------------------
// writable bit masks, unavailable bits read zero
// ----------------------------------------------------------------------
`define BDCR_MASK_CMD        8'h1B
`define BDCR_MASK_DRV_IN     8'h0F
`define BDCR_MASK_CFG_FAULT  8'hFF
`define BDCR_MASK_CFG_DIAG   8'hE7
`define BDCR_MASK_CFG_TIME   8'hDF
`define BDCR_MASK_CFG_COMB   8'hDF

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BDCR_CMD_CLR_BIT     7
`define BDCR_CMD_INLK_HI     4
`define BDCR_CMD_INLK_LO     3
`define BDCR_CMD_CFLK_HI     1
`define BDCR_CMD_CFLK_LO     0
`define BDCR_IN_OFF1_BIT     3
`define BDCR_IN_OFF2_BIT     2
`define BDCR_IN_EN1_BIT      1
`define BDCR_IN_PH2_BIT      0
`define BDCR_CF_OLA_EN_BIT   7
`define BDCR_CF_OV_HI        6
`define BDCR_CF_OV_LO        5
`define BDCR_CF_SSC_BIT      4
`define BDCR_CF_OCP_RT_BIT   3
`define BDCR_CF_TSD_RT_BIT   2
`define BDCR_CF_OV_RT_BIT    1
`define BDCR_CF_OLA_RT_BIT   0
`define BDCR_CD_EXT_BIT      7
`define BDCR_CD_DIAG_HI      6
`define BDCR_CD_DIAG_LO      5
`define BDCR_CD_TRIP_HI      2
`define BDCR_CD_TRIP_LO      0
`define BDCR_CT_REGULATION_OFF_TIME_HI      7
`define BDCR_CT_REGULATION_OFF_TIME_LO      6
`define BDCR_CT_SR_HI        4
`define BDCR_CT_SR_LO        2
`define BDCR_CT_MODE_HI      1
`define BDCR_CT_MODE_LO      0
`define BDCR_CC_OFF_SEL_BIT  2
`define BDCR_CC_EN1_SEL_BIT  1
`define BDCR_CC_PH2_SEL_BIT  0

// ----------------------------------------------------------------------
// lock codes, overvoltage codes
// ----------------------------------------------------------------------
`define BDCR_INLK_UNLOCK     2'b10
`define BDCR_CFLK_LOCK       2'b10
`define BDCR_OV_DISABLED     2'b11

// ----------------------------------------------------------------------
// timing: off time base and step in microseconds, clock in MHz
// ----------------------------------------------------------------------
`define BDCR_REGULATION_OFF_TIME_BASE_US    20
`define BDCR_REGULATION_OFF_TIME_STEP_US    10
`define BDCR_CLK_MHZ         40
`define BDCR_REGULATION_OFF_TIME_CNT_W      12

`endif

// ---- bdcr_sync.v ----
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps

module bdcr_sync #(
    parameter RST_VAL = 1'b0
) (
    // clock and reset
    input  wire clk,
    input  wire arst_n,
    // data
    input  wire d,
    output wire q
);

    reg meta_q;
    reg sync_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule // bdcr_sync

// ---- bdcr_regs.v ----
// serial-port command and configuration register bank of a bridge driver
//
// Contract
// - fault clear releases faults and indicator
// - only 10b unlocks drive-input register copy
// - 10b locks configuration, others unlock
// - bit 3 mirrors shutoff pin, bridge1
// - bit 2 shuts bridge 2 independently
// - bit 1 mirrors enable/input-1 pin
// - bit 0 mirrors phase/input-2 pin
// - open-load active detection enable bit
// - independent low-side load disables open-load
// - overvoltage threshold select, 11b disables
// - spread spectrum off bit resets one
// - overcurrent reaction retry or latch
// - overtemperature reaction retry or latch
// - overvoltage and undervoltage reaction select
// - open-load reaction retry or latch
// - extra coast states in pulse mode
// - load-type selection bits six to five
// - current-trip level bits two to zero
// - off-time field twenty to fifty microseconds
// - slew rate selection bits four-two
// - bridge control mode bits one-zero
// - unavailable bits read back zero; combine register bits 7-6 and 4-3 keep their written values
// - shutoff pin combine select, default AND
// - input pins combine select, default OR
`timescale 1ns/1ps
`include "bdcr_defines.vh"

module bdcr_regs #(
    parameter [1:0] INDEP_MODE = 2'b10
) (
    // clock and reset
    input  wire       clk,
    input  wire       arst_n,
    // serial port
    input  wire       sclk,
    input  wire       cs_n,
    input  wire       sdi,
    output reg        sdo,
    output reg        sdo_oe,
    // drive pins
    input  wire       shutoff_pin,
    input  wire       enable_input1_pin,
    input  wire       phase_input2_pin,
    // fault logic
    input  wire [7:0] fault_summary,
    input  wire       fault_event,
    input  wire       load_low_side,
    output reg        fault_clear_cmd,
    output reg        fault_indicator_n,
    output reg        fault_indicator_n_oe,
    // effective drive inputs
    output reg        bridge1_off,
    output reg        bridge2_off,
    output reg        eff_enable_input1,
    output reg        eff_phase_input2,
    // configuration outputs
    output reg        openload_active_en,
    output reg [1:0]  overvoltage_threshold,
    output reg        overvoltage_det_en,
    output reg        spread_spectrum_off,
    output reg        overcurrent_retry,
    output reg        overtemp_retry,
    output reg        overvoltage_retry,
    output reg        openload_retry,
    output reg        pwm_coast_extend,
    output reg [1:0]  load_type_sel,
    output reg [2:0]  current_trip_level,
    output reg [1:0]  regulation_off_time,
    output reg [`BDCR_REGULATION_OFF_TIME_CNT_W-1:0] off_time_cycles,
    output reg [2:0]  slew_rate_sel,
    output reg [1:0]  bridge_mode
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    wire sclk_s;
    wire cs_n_s;
    wire sdi_s;
    wire off_pin_s;
    wire en_pin_s;
    wire ph_pin_s;

    bdcr_sync #(.RST_VAL(1'b0)) u_sync_sclk (
        .clk(clk), .arst_n(arst_n), .d(sclk), .q(sclk_s));
    bdcr_sync #(.RST_VAL(1'b1)) u_sync_cs (
        .clk(clk), .arst_n(arst_n), .d(cs_n), .q(cs_n_s));
    bdcr_sync #(.RST_VAL(1'b0)) u_sync_sdi (
        .clk(clk), .arst_n(arst_n), .d(sdi), .q(sdi_s));
    bdcr_sync #(.RST_VAL(1'b1)) u_sync_off (
        .clk(clk), .arst_n(arst_n), .d(shutoff_pin), .q(off_pin_s));
    bdcr_sync #(.RST_VAL(1'b0)) u_sync_en (
        .clk(clk), .arst_n(arst_n), .d(enable_input1_pin),
        .q(en_pin_s));
    bdcr_sync #(.RST_VAL(1'b0)) u_sync_ph (
        .clk(clk), .arst_n(arst_n), .d(phase_input2_pin),
        .q(ph_pin_s));

    // ------------------------------------------------------------------
    // registers and frame state
    // ------------------------------------------------------------------
    reg  [7:0]  cmd_q;
    reg  [7:0]  drv_in_q;
    reg  [7:0]  cfg_fault_q;
    reg  [7:0]  cfg_diag_q;
    reg  [7:0]  cfg_time_q;
    reg  [7:0]  cfg_comb_q;
    reg         sclk_d1_q;
    reg         cs_d1_q;
    reg  [4:0]  bit_cnt_q;
    reg  [15:0] rx_q;
    reg  [15:0] tx_q;
    reg         fault_latched_q;
    reg  [7:0]  rdata;

    wire sclk_rise  = sclk_s & ~sclk_d1_q;
    wire sclk_fall  = ~sclk_s & sclk_d1_q;
    wire cs_start   = ~cs_n_s & cs_d1_q;
    wire cs_end     = cs_n_s & ~cs_d1_q;
    wire frame_ok   = (bit_cnt_q == 5'd16);
    // header: bit 14 high marks a read
    wire frame_wr   = cs_end & frame_ok & ~rx_q[14];
    wire [5:0] waddr = rx_q[13:8];
    wire [7:0] wdata = rx_q[7:0];
    wire in_unlocked = (cmd_q[`BDCR_CMD_INLK_HI:`BDCR_CMD_INLK_LO]
                        == `BDCR_INLK_UNLOCK);
    wire cfg_locked  = (cmd_q[`BDCR_CMD_CFLK_HI:`BDCR_CMD_CFLK_LO]
                        == `BDCR_CFLK_LOCK);
    wire clr_write   = frame_wr && (waddr == `BDCR_ADDR_CMD) &&
                       wdata[`BDCR_CMD_CLR_BIT];

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always @* begin
        // address ends with the bit sampled on the 8th rise
        case ({rx_q[4:0], sdi_s})
            `BDCR_ADDR_CMD:       rdata = cmd_q;
            `BDCR_ADDR_DRV_IN:    rdata = drv_in_q;
            `BDCR_ADDR_CFG_FAULT: rdata = cfg_fault_q;
            `BDCR_ADDR_CFG_DIAG:  rdata = cfg_diag_q;
            `BDCR_ADDR_CFG_TIME:  rdata = cfg_time_q;
            `BDCR_ADDR_CFG_COMB:  rdata = cfg_comb_q;
            default:              rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // serial frame engine
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_d1_q <= 1'b0;
            cs_d1_q   <= 1'b1;
            bit_cnt_q <= 5'd0;
            rx_q      <= 16'h0000;
            tx_q      <= 16'h0000;
            sdo       <= 1'b0;
            sdo_oe    <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_s;
            cs_d1_q   <= cs_n_s;
            sdo_oe    <= ~cs_n_s;
            if (cs_start) begin
                bit_cnt_q <= 5'd0;
                tx_q      <= {fault_summary, 8'h00};
                sdo       <= fault_summary[7];
            end else if (!cs_n_s) begin
                if (sclk_rise && bit_cnt_q != 5'd16) begin
                    rx_q      <= {rx_q[14:0], sdi_s};
                    bit_cnt_q <= bit_cnt_q + 5'd1;
                    // header complete: place read data behind it
                    if (bit_cnt_q == 5'd7)
                        tx_q <= {tx_q[15], rdata, 7'h00};
                end else if (sclk_fall) begin
                    tx_q <= {tx_q[14:0], 1'b0};
                    sdo  <= tx_q[14];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_q       <= `BDCR_RST_CMD;
            drv_in_q    <= `BDCR_RST_DRV_IN;
            cfg_fault_q <= `BDCR_RST_CFG_FAULT;
            cfg_diag_q  <= `BDCR_RST_CFG_DIAG;
            cfg_time_q  <= `BDCR_RST_CFG_TIME;
            cfg_comb_q  <= `BDCR_RST_CFG_COMB;
        end else if (frame_wr) begin
            case (waddr)
                // clear bit self-clears, n/a bits zero
                `BDCR_ADDR_CMD:
                    cmd_q <= wdata & `BDCR_MASK_CMD;
                `BDCR_ADDR_DRV_IN:
                    drv_in_q <= wdata & `BDCR_MASK_DRV_IN;
                default: begin
                    if (!cfg_locked) begin
                        if (waddr == `BDCR_ADDR_CFG_FAULT)
                            cfg_fault_q <= wdata & `BDCR_MASK_CFG_FAULT;
                        if (waddr == `BDCR_ADDR_CFG_DIAG)
                            cfg_diag_q <= wdata & `BDCR_MASK_CFG_DIAG;
                        if (waddr == `BDCR_ADDR_CFG_TIME)
                            cfg_time_q <= wdata & `BDCR_MASK_CFG_TIME;
                        if (waddr == `BDCR_ADDR_CFG_COMB)
                            cfg_comb_q <= wdata & `BDCR_MASK_CFG_COMB;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // fault clear and indicator
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_latched_q      <= 1'b0;
            fault_clear_cmd      <= 1'b0;
            fault_indicator_n    <= 1'b0;
            fault_indicator_n_oe <= 1'b0;
        end else begin
            fault_clear_cmd <= clr_write;
            if (fault_event)
                fault_latched_q <= 1'b1;
            else if (clr_write)
                fault_latched_q <= 1'b0;
            fault_indicator_n    <= 1'b0;
            fault_indicator_n_oe <= fault_event |
                                    (fault_latched_q & ~clr_write);
        end
    end

    // ------------------------------------------------------------------
    // effective drive inputs
    // ------------------------------------------------------------------
    wire indep   = (cfg_time_q[`BDCR_CT_MODE_HI:`BDCR_CT_MODE_LO]
                    == INDEP_MODE);
    // shutoff combine: 0 or, 1 and
    wire off_c1  = cfg_comb_q[`BDCR_CC_OFF_SEL_BIT] ?
                   (off_pin_s & drv_in_q[`BDCR_IN_OFF1_BIT]) :
                   (off_pin_s | drv_in_q[`BDCR_IN_OFF1_BIT]);
    wire off_c2  = cfg_comb_q[`BDCR_CC_OFF_SEL_BIT] ?
                   (off_pin_s & drv_in_q[`BDCR_IN_OFF2_BIT]) :
                   (off_pin_s | drv_in_q[`BDCR_IN_OFF2_BIT]);
    wire en_c    = cfg_comb_q[`BDCR_CC_EN1_SEL_BIT] ?
                   (en_pin_s & drv_in_q[`BDCR_IN_EN1_BIT]) :
                   (en_pin_s | drv_in_q[`BDCR_IN_EN1_BIT]);
    wire ph_c    = cfg_comb_q[`BDCR_CC_PH2_SEL_BIT] ?
                   (ph_pin_s & drv_in_q[`BDCR_IN_PH2_BIT]) :
                   (ph_pin_s | drv_in_q[`BDCR_IN_PH2_BIT]);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bridge1_off       <= 1'b1;
            bridge2_off       <= 1'b1;
            eff_enable_input1 <= 1'b0;
            eff_phase_input2  <= 1'b0;
        end else if (in_unlocked) begin
            // bit 3 stands for the shutoff pin
            bridge1_off       <= off_c1;
            // in independent mode bit 2 shuts half-bridge 2 alone, else bridge 2 follows bit 3
            bridge2_off       <= indep ? off_c2 : off_c1;
            eff_enable_input1 <= en_c;
            eff_phase_input2  <= ph_c;
        end else begin
            bridge1_off       <= off_pin_s;
            bridge2_off       <= off_pin_s;
            eff_enable_input1 <= en_pin_s;
            eff_phase_input2  <= ph_pin_s;
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            openload_active_en    <= 1'b0;
            overvoltage_threshold <= 2'b00;
            overvoltage_det_en    <= 1'b1;
            spread_spectrum_off   <= 1'b1;
            overcurrent_retry     <= 1'b0;
            overtemp_retry        <= 1'b0;
            overvoltage_retry     <= 1'b0;
            openload_retry        <= 1'b0;
            pwm_coast_extend      <= 1'b0;
            load_type_sel         <= 2'b00;
            current_trip_level    <= 3'b000;
            regulation_off_time   <= 2'b01;
            off_time_cycles       <= `BDCR_REGULATION_OFF_TIME_CNT_W'h000;
            slew_rate_sel         <= 3'b000;
            bridge_mode           <= 2'b00;
        end else begin
            openload_active_en <= cfg_fault_q[`BDCR_CF_OLA_EN_BIT] &
                                  ~(indep & load_low_side);
            overvoltage_threshold <=
                cfg_fault_q[`BDCR_CF_OV_HI:`BDCR_CF_OV_LO];
            overvoltage_det_en <=
                (cfg_fault_q[`BDCR_CF_OV_HI:`BDCR_CF_OV_LO]
                 != `BDCR_OV_DISABLED);
            spread_spectrum_off <= cfg_fault_q[`BDCR_CF_SSC_BIT];
            overcurrent_retry <= cfg_fault_q[`BDCR_CF_OCP_RT_BIT];
            overtemp_retry    <= cfg_fault_q[`BDCR_CF_TSD_RT_BIT];
            overvoltage_retry <= cfg_fault_q[`BDCR_CF_OV_RT_BIT];
            openload_retry    <= cfg_fault_q[`BDCR_CF_OLA_RT_BIT];
            pwm_coast_extend  <= cfg_diag_q[`BDCR_CD_EXT_BIT];
            load_type_sel <= cfg_diag_q[`BDCR_CD_DIAG_HI:`BDCR_CD_DIAG_LO];
            current_trip_level <=
                cfg_diag_q[`BDCR_CD_TRIP_HI:`BDCR_CD_TRIP_LO];
            regulation_off_time <=
                cfg_time_q[`BDCR_CT_REGULATION_OFF_TIME_HI:`BDCR_CT_REGULATION_OFF_TIME_LO];
            off_time_cycles <= regulation_off_time_cycles(
                cfg_time_q[`BDCR_CT_REGULATION_OFF_TIME_HI:`BDCR_CT_REGULATION_OFF_TIME_LO]);
            slew_rate_sel <= cfg_time_q[`BDCR_CT_SR_HI:`BDCR_CT_SR_LO];
            bridge_mode   <= cfg_time_q[`BDCR_CT_MODE_HI:`BDCR_CT_MODE_LO];
        end
    end

    // off time: base plus code steps, times clock rate
    function [`BDCR_REGULATION_OFF_TIME_CNT_W-1:0] regulation_off_time_cycles;
        input [1:0] code;
        integer us;
        integer cyc;
        begin
            us  = `BDCR_REGULATION_OFF_TIME_BASE_US + code * `BDCR_REGULATION_OFF_TIME_STEP_US;
            cyc = us * `BDCR_CLK_MHZ;
            regulation_off_time_cycles = cyc[`BDCR_REGULATION_OFF_TIME_CNT_W-1:0];
        end
    endfunction

endmodule // bdcr_regs

// ---- bdcr_regs_sva.sv ----
// assertion checker for the bridge driver register bank
`timescale 1ns/1ps
`include "bdcr_defines.vh"

module bdcr_regs_sva #(
    parameter [1:0] INDEP_MODE = 2'b10
) (
    // clock and reset
    input wire       clk,
    input wire       arst_n,
    // serial port and fault logic
    input wire       cs_n,
    input wire       sdo_oe,
    input wire       fault_event,
    input wire       load_low_side,
    input wire       fault_clear_cmd,
    input wire       fault_indicator_n,
    input wire       fault_indicator_n_oe,
    // configuration outputs
    input wire       bridge1_off,
    input wire       bridge2_off,
    input wire       openload_active_en,
    input wire [1:0] overvoltage_threshold,
    input wire       overvoltage_det_en,
    input wire [1:0] regulation_off_time,
    input wire [`BDCR_REGULATION_OFF_TIME_CNT_W-1:0] off_time_cycles,
    input wire [1:0] bridge_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ------------
    // assertions
    // ------------
    ov_det_a: assert property (
        overvoltage_det_en == (overvoltage_threshold != 2'b11))
        else $error("overvoltage enable disagrees with threshold code");
    off_time_a: assert property ($stable(regulation_off_time) [*2] |->
        off_time_cycles == 12'h320 + 12'h190 * regulation_off_time)
        else $error("off time count wrong for code");
    clr_pulse_a: assert property (fault_clear_cmd |=> !fault_clear_cmd)
        else $error("fault clear longer than one cycle");
    clr_release_a: assert property (
        fault_clear_cmd && !$past(fault_event) |-> !fault_indicator_n_oe)
        else $error("fault indicator not released by clear");
    fault_set_a: assert property (
        fault_event |-> ##1 fault_indicator_n_oe)
        else $error("fault indicator not pulled low");
    ind_low_a: assert property (fault_indicator_n == 1'b0)
        else $error("open drain value not low");
    sdo_idle_a: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("data out driven while deselected");
    sdo_start_a: assert property ($fell(cs_n) |-> ##[1:5] sdo_oe)
        else $error("data out not enabled after select");
    ola_low_a: assert property (
        (bridge_mode == INDEP_MODE && load_low_side)
        ##1 ($stable(bridge_mode) && load_low_side) |-> !openload_active_en)
        else $error("open load active with low side load");
    br2_follow_a: assert property (($stable(bridge_mode) &&
        bridge_mode != INDEP_MODE) [*2] |-> bridge2_off == bridge1_off)
        else $error("bridge two shutoff differs in full bridge mode");

    clr_c: cover property (fault_clear_cmd);
    frame_c: cover property ($fell(cs_n));
    ola_c: cover property (bridge_mode == INDEP_MODE && load_low_side);
endmodule // bdcr_regs_sva

bind bdcr_regs bdcr_regs_sva #(.INDEP_MODE(INDEP_MODE)) u_sva (
    .clk, .arst_n, .cs_n, .sdo_oe, .fault_event, .load_low_side,
    .fault_clear_cmd, .fault_indicator_n, .fault_indicator_n_oe,
    .bridge1_off, .bridge2_off, .openload_active_en, .overvoltage_threshold,
    .overvoltage_det_en, .regulation_off_time, .off_time_cycles, .bridge_mode
);

// ---- bdcr_host.sv ----
// host controller model acting as serial bus master
`timescale 1ns/1ps

module bdcr_host (
    // clock
    input  wire clk,
    // serial port
    output reg  sclk,
    output reg  cs_n,
    output reg  sdi,
    input  wire sdo
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    task automatic xfer(input logic rd, input logic [5:0] adr,
                        input logic [7:0] wd, output logic [15:0] rx);
        logic [15:0] tx;
        tx = {1'b0, rd, adr, wd};
        @(negedge clk) cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(negedge clk) sdi = tx[i];
            repeat (6) @(negedge clk);
            rx[i] = sdo;
            sclk = 1'b1;
            repeat (6) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (6) @(negedge clk);
        cs_n = 1'b1;
        // released line shows no stale bit
        sdi = ~sdi;
        repeat (6) @(negedge clk);
    endtask
endmodule // bdcr_host

// ---- bdcr_regs_tb.sv ----
// self-checking testbench for the bridge driver register bank
`timescale 1ns/1ps
`include "bdcr_defines.vh"

module bdcr_regs_tb;
    logic        clk, arst_n, fault_event, load_low_side;
    logic        shutoff_pin, enable_input1_pin, phase_input2_pin;
    logic [7:0]  fault_summary;
    wire         sclk, cs_n, sdi, sdo;
    wire         fault_clear_cmd, fault_indicator_n, fault_indicator_n_oe;
    wire         bridge1_off, bridge2_off, eff_enable_input1, eff_phase_input2;
    wire         openload_active_en, overvoltage_det_en, spread_spectrum_off;
    wire         overcurrent_retry, overtemp_retry, overvoltage_retry;
    wire         openload_retry, pwm_coast_extend;
    wire [1:0]   overvoltage_threshold, load_type_sel, regulation_off_time;
    wire [1:0]   bridge_mode;
    wire [2:0]   current_trip_level, slew_rate_sel;
    wire [`BDCR_REGULATION_OFF_TIME_CNT_W-1:0] off_time_cycles;
    int          n_mismatch, cmp_count, n_clr;
    logic [7:0]  rst_tab [6] = '{8'h09, 8'h0C, 8'h10, 8'h00, 8'h40, 8'h04};
    logic [7:0]  msk_tab [5] = '{8'h1B, 8'h0F, 8'hFF, 8'hE7, 8'hDF};

    bdcr_regs DUT (.clk, .arst_n, .sclk, .cs_n, .sdi, .sdo, .sdo_oe(),
        .shutoff_pin, .enable_input1_pin, .phase_input2_pin, .fault_summary,
        .fault_event, .load_low_side, .fault_clear_cmd, .fault_indicator_n,
        .fault_indicator_n_oe, .bridge1_off, .bridge2_off, .eff_enable_input1,
        .eff_phase_input2, .openload_active_en, .overvoltage_threshold,
        .overvoltage_det_en, .spread_spectrum_off, .overcurrent_retry,
        .overtemp_retry, .overvoltage_retry, .openload_retry, .pwm_coast_extend,
        .load_type_sel, .current_trip_level, .regulation_off_time,
        .off_time_cycles, .slew_rate_sel, .bridge_mode);
    bdcr_host host (.clk, .sclk, .cs_n, .sdi, .sdo);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (fault_clear_cmd === 1'b1) n_clr <= n_clr + 1;

    // ------------
    // shared tasks
    // ------------
    task automatic chk(input string nm, input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] rx;
        host.xfer(1'b0, a, d, rx);
        chk("status byte", rx[15:8], fault_summary);
        repeat (6) @(negedge clk);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        logic [15:0] rx;
        host.xfer(1'b1, a, 8'h00, rx);
        d = rx[7:0];
    endtask
    task automatic finish_test;
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ------------
    // scenarios
    // ------------
    task automatic t_reset;
        logic [7:0] v;
        for (int i = 0; i < 6; i++) begin
            rd(6'h08 + i[5:0], v);
            chk("reset value", v, rst_tab[i]);
        end
        chk("spread off", spread_spectrum_off, 1'b1);
    endtask
    task automatic t_mask;
        logic [7:0] v;
        for (int i = 0; i < 5; i++) begin
            wr(6'h08 + i[5:0], 8'hFF);
            rd(6'h08 + i[5:0], v);
            chk("read mask", v, msk_tab[i]);
        end
        chk("retry bits", {overcurrent_retry, overtemp_retry,
            overvoltage_retry, openload_retry}, 4'hF);
        chk("fields", {pwm_coast_extend, load_type_sel, current_trip_level,
            slew_rate_sel, bridge_mode}, 11'h7FF);
    endtask
    task automatic t_lock;
        logic [7:0] v;
        wr(6'h08, 8'h0A);
        wr(6'h0A, 8'h00);
        rd(6'h0A, v);
        chk("locked cfg", v, 8'hFF);
        wr(6'h08, 8'h09);
        wr(6'h0A, 8'h00);
        rd(6'h0A, v);
        chk("unlocked cfg", v, 8'h00);
    endtask
    task automatic t_clear;
        int n0;
        @(negedge clk) fault_event = 1'b1;
        @(negedge clk) fault_event = 1'b0;
        repeat (2) @(negedge clk);
        chk("fault shown", fault_indicator_n_oe, 1'b1);
        n0 = n_clr;
        wr(6'h08, 8'h89);
        chk("clear pulses", n_clr - n0, 1);
        chk("fault released", fault_indicator_n_oe, 1'b0);
    endtask
    task automatic t_inputs;
        chk("locked pins", {bridge1_off, eff_enable_input1,
            eff_phase_input2}, 3'b000);
        wr(6'h08, 8'h11);
        chk("or combine", {bridge1_off, eff_enable_input1,
            eff_phase_input2}, 3'b011);
        wr(6'h0D, 8'h03);
        chk("and combine", {eff_enable_input1, eff_phase_input2}, 2'b00);
        wr(6'h0D, 8'h00);
        chk("shutoff or", bridge1_off, 1'b1);
        wr(6'h0C, 8'h02);
        wr(6'h09, 8'h04);
        chk("half bridges", {bridge1_off, bridge2_off}, 2'b01);
        @(negedge clk) shutoff_pin = 1'b1;
        repeat (4) @(negedge clk);
        chk("pin shutoff", bridge1_off, 1'b1);
        wr(6'h0A, 8'h80);
        load_low_side = 1'b1;
        repeat (3) @(negedge clk);
        chk("low side ola", openload_active_en, 1'b0);
        load_low_side = 1'b0;
        repeat (3) @(negedge clk);
        chk("ola enable", openload_active_en, 1'b1);
        wr(6'h08, 8'h09);
        shutoff_pin = 1'b0;
        enable_input1_pin = 1'b1;
        repeat (4) @(negedge clk);
        chk("relocked pins", {bridge1_off, eff_enable_input1,
            eff_phase_input2}, 3'b010);
    endtask
    task automatic t_codes;
        for (int k = 0; k < 4; k++) begin
            wr(6'h0A, {1'b0, k[1:0], 5'h00});
            wr(6'h0C, {k[1:0], 6'h00});
            chk("ov code", overvoltage_threshold, k[1:0]);
            chk("ov enable", overvoltage_det_en, k != 3);
            chk("off time", off_time_cycles, (20 + 10 * k) * 40);
        end
        chk("spread on", spread_spectrum_off, 1'b0);
        chk("latched", {overcurrent_retry, openload_retry}, 2'b00);
    endtask

    initial begin
        arst_n = 1'b0;
        fault_summary = 8'hA5;
        fault_event = 1'b0;
        load_low_side = 1'b0;
        shutoff_pin = 1'b0;
        enable_input1_pin = 1'b0;
        phase_input2_pin = 1'b0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset;
        t_mask;
        t_lock;
        t_clear;
        t_inputs;
        t_codes;
        finish_test;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        finish_test;
    end
endmodule // bdcr_regs_tb
